// ### hw/misv_defs.svh
`ifndef MISV_DEFS_SVH
`define MISV_DEFS_SVH

// word addresses on the voted processor bus
`define MISV_ADDR_INPUT 3'h0
`define MISV_ADDR_LINE 3'h1
`define MISV_ADDR_TOFF 3'h2
`define MISV_ADDR_TON 3'h3
`define MISV_ADDR_REFRB 3'h4
`define MISV_ADDR_IDENT 3'h5
`define MISV_ADDR_LOOP 3'h6
`define MISV_ADDR_CMD 3'h7

// command word bit positions
`define MISV_CMD_TEST 0
`define MISV_CMD_FAULT 1
`define MISV_CMD_CLEAR 2
`define MISV_CMD_LMON 3

// reference readback word layout
`define MISV_RB_DONE 15
`define MISV_RB_CMPOK 14

// identification code: arbitrary value
`define MISV_IDENT_CODE 16'hC5A1

// reference levels in millivolts, as configured
`define MISV_REF_SHORT_MV 4000
`define MISV_REF_ONOFF_MV 12000
`define MISV_REF_OPEN_MV 20000
`define MISV_REF_STUCKOFF_MV (-5000)
`define MISV_REF_STUCKON_MV 32000
// converter scale: code = (mv + offset) / step
`define MISV_DAC_OFFSET_MV 8000
`define MISV_DAC_STEP_MV 250

// reference settling time and clock
`define MISV_SETTLE_NS 2000
`define MISV_CLK_NS 8
`define MISV_SETTLE_CYC ((`MISV_SETTLE_NS + `MISV_CLK_NS - 1) / `MISV_CLK_NS)

`endif

// ### hw/misv_pkg.sv
package misv_pkg;

    typedef enum logic [1:0] {
        MISV_SET,
        MISV_SETTLE,
        MISV_LATCH
    } misv_state_e;

    typedef logic [15:0] misv_word_t;
    typedef logic [2:0] misv_addr_t;

endpackage

// ### hw/misv_vote3.sv
`timescale 1ns/100ps
module misv_vote3 #(
    parameter int W = 1
) (
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire logic [W-1:0] c_i,
    output logic [W-1:0] y_o,
    output logic disagree_o
);
    // bitwise two-of-three majority
    assign y_o = (a_i & b_i) | (a_i & c_i) | (b_i & c_i);
    assign disagree_o = (a_i != b_i) || (a_i != c_i);
endmodule

// ### hw/misv_top.sv
`timescale 1ns/100ps
`include "misv_defs.svh"
module misv_top import misv_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] cmp_i,
    input wire logic [7:0] ref_mon_i,
    input wire logic ac_variant_i,
    input wire logic [2:0] bus_a_addr_i,
    input wire logic bus_a_rd_i,
    input wire logic bus_a_wr_i,
    input wire logic [15:0] bus_a_wdata_i,
    input wire logic [2:0] bus_b_addr_i,
    input wire logic bus_b_rd_i,
    input wire logic bus_b_wr_i,
    input wire logic [15:0] bus_b_wdata_i,
    input wire logic [2:0] bus_c_addr_i,
    input wire logic bus_c_rd_i,
    input wire logic bus_c_wr_i,
    input wire logic [15:0] bus_c_wdata_i,
    output logic [15:0] bus_a_rdata_o,
    output logic bus_a_rdata_oe_o,
    output logic [15:0] bus_b_rdata_o,
    output logic bus_b_rdata_oe_o,
    output logic [15:0] bus_c_rdata_o,
    output logic bus_c_rdata_oe_o,
    output logic [7:0] dac_code_o,
    output logic led_active_o,
    output logic led_fault_o,
    output logic [15:0] led_contact_o,
    output logic [15:0] led_line_o
);
    localparam int SETTLE_CYC = `MISV_SETTLE_CYC;
    localparam int LEG_W = 3 + 1 + 1 + 16;

    // mv to converter code, halved for the AC variant
    function automatic logic [7:0] ref_code(input int mv, input logic half);
        int v;
        v = half ? (mv / 2) : mv;
        ref_code = 8'((v + `MISV_DAC_OFFSET_MV) / `MISV_DAC_STEP_MV);
    endfunction

    // pin synchronisers
    logic [15:0] cmp_s1_r, cmp_s2_r;
    logic [7:0] rmon_s1_r, rmon_s2_r;
    logic ac_s1_r, ac_s2_r;
    logic [3*LEG_W-1:0] leg_s1_r, leg_s2_r;
    logic [3*LEG_W-1:0] leg_raw;

    assign leg_raw = {bus_a_addr_i, bus_a_rd_i, bus_a_wr_i, bus_a_wdata_i,
                      bus_b_addr_i, bus_b_rd_i, bus_b_wr_i, bus_b_wdata_i,
                      bus_c_addr_i, bus_c_rd_i, bus_c_wr_i, bus_c_wdata_i};

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmp_s1_r <= 16'h0000;
            cmp_s2_r <= 16'h0000;
            rmon_s1_r <= 8'h00;
            rmon_s2_r <= 8'h00;
            ac_s1_r <= 1'b0;
            ac_s2_r <= 1'b0;
            leg_s1_r <= '0;
            leg_s2_r <= '0;
        end else begin
            cmp_s1_r <= cmp_i;
            cmp_s2_r <= cmp_s1_r;
            rmon_s1_r <= ref_mon_i;
            rmon_s2_r <= rmon_s1_r;
            ac_s1_r <= ac_variant_i;
            ac_s2_r <= ac_s1_r;
            leg_s1_r <= leg_raw;
            leg_s2_r <= leg_s1_r;
        end
    end

    // voted request path
    logic [LEG_W-1:0] leg_a, leg_b, leg_c, leg_v;
    misv_addr_t addr_v;
    logic rd_v, wr_v;
    misv_word_t wdata_v;

    assign leg_a = leg_s2_r[3*LEG_W-1:2*LEG_W];
    assign leg_b = leg_s2_r[2*LEG_W-1:LEG_W];
    assign leg_c = leg_s2_r[LEG_W-1:0];

    misv_vote3 #(.W(LEG_W)) u_vote (
        .a_i(leg_a),
        .b_i(leg_b),
        .c_i(leg_c),
        .y_o(leg_v),
        .disagree_o()
    );
    assign {addr_v, rd_v, wr_v, wdata_v} = leg_v;

    // field-side scan sequencer
    misv_state_e st_r, st_nxt;
    logic [2:0] lvl_r, lvl_nxt;
    logic [8:0] settle_r, settle_nxt;
    logic [7:0] dac_r, dac_nxt;
    logic test_run_r, test_run_nxt;
    logic [15:0] smp_short_r, smp_short_nxt;
    logic [15:0] smp_onoff_r, smp_onoff_nxt;
    logic [15:0] smp_open_r, smp_open_nxt;
    logic [15:0] smp_toff_r, smp_toff_nxt;
    logic [15:0] smp_ton_r, smp_ton_nxt;
    logic [7:0] rmon_r, rmon_nxt;
    logic cmp_ok_r, cmp_ok_nxt;
    logic xfer_r, xfer_nxt;
    logic xfer_test_r, xfer_test_nxt;
    logic test_pend_r;
    logic last_lvl;

    assign last_lvl = test_run_r ? (lvl_r == 3'd4) : (lvl_r == 3'd2);

    always_comb begin
        st_nxt = st_r;
        lvl_nxt = lvl_r;
        settle_nxt = settle_r;
        dac_nxt = dac_r;
        test_run_nxt = test_run_r;
        smp_short_nxt = smp_short_r;
        smp_onoff_nxt = smp_onoff_r;
        smp_open_nxt = smp_open_r;
        smp_toff_nxt = smp_toff_r;
        smp_ton_nxt = smp_ton_r;
        rmon_nxt = rmon_r;
        cmp_ok_nxt = cmp_ok_r;
        xfer_nxt = 1'b0;
        xfer_test_nxt = 1'b0;
        case (st_r)
            MISV_SET: begin
                case (lvl_r)
                    3'd0: dac_nxt = ref_code(`MISV_REF_SHORT_MV, ac_s2_r);
                    3'd1: dac_nxt = ref_code(`MISV_REF_ONOFF_MV, ac_s2_r);
                    3'd2: dac_nxt = ref_code(`MISV_REF_OPEN_MV, ac_s2_r);
                    3'd3: dac_nxt = ref_code(`MISV_REF_STUCKOFF_MV, ac_s2_r);
                    default: dac_nxt = ref_code(`MISV_REF_STUCKON_MV, ac_s2_r);
                endcase
                settle_nxt = 9'(SETTLE_CYC - 1);
                st_nxt = MISV_SETTLE;
            end
            MISV_SETTLE: begin
                // latching early would catch the previous threshold
                if (settle_r == 9'd0) begin
                    st_nxt = MISV_LATCH;
                end else begin
                    settle_nxt = settle_r - 9'd1;
                end
            end
            MISV_LATCH: begin
                // all sixteen points sampled in one cycle
                case (lvl_r)
                    3'd0: smp_short_nxt = cmp_s2_r;
                    3'd1: smp_onoff_nxt = cmp_s2_r;
                    3'd2: smp_open_nxt = cmp_s2_r;
                    3'd3: smp_toff_nxt = cmp_s2_r;
                    default: smp_ton_nxt = cmp_s2_r;
                endcase
                // reference monitored against the code driven
                if (lvl_r == 3'd0) begin
                    cmp_ok_nxt = 1'b1;
                end
                if (rmon_s2_r != dac_r) begin
                    cmp_ok_nxt = 1'b0;
                end
                rmon_nxt = rmon_s2_r;
                st_nxt = MISV_SET;
                if (last_lvl) begin
                    lvl_nxt = 3'd0;
                    xfer_nxt = 1'b1;
                    // test_run_r switches with xfer_r, so the finished mode rides along
                    xfer_test_nxt = test_run_r;
                    test_run_nxt = test_pend_r;
                end else begin
                    lvl_nxt = lvl_r + 3'd1;
                end
            end
            default: st_nxt = MISV_SET;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= MISV_SET;
            lvl_r <= 3'd0;
            settle_r <= 9'd0;
            dac_r <= 8'h00;
            test_run_r <= 1'b0;
            smp_short_r <= 16'h0000;
            smp_onoff_r <= 16'h0000;
            smp_open_r <= 16'h0000;
            smp_toff_r <= 16'h0000;
            smp_ton_r <= 16'h0000;
            rmon_r <= 8'h00;
            cmp_ok_r <= 1'b0;
            xfer_r <= 1'b0;
            xfer_test_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            lvl_r <= lvl_nxt;
            settle_r <= settle_nxt;
            dac_r <= dac_nxt;
            test_run_r <= test_run_nxt;
            smp_short_r <= smp_short_nxt;
            smp_onoff_r <= smp_onoff_nxt;
            smp_open_r <= smp_open_nxt;
            smp_toff_r <= smp_toff_nxt;
            smp_ton_r <= smp_ton_nxt;
            rmon_r <= rmon_nxt;
            cmp_ok_r <= cmp_ok_nxt;
            xfer_r <= xfer_nxt;
            xfer_test_r <= xfer_test_nxt;
        end
    end

    // logic side: held copies, decode, bus, LEDs
    misv_word_t in_st_r, in_st_nxt;
    misv_word_t ln_st_r, ln_st_nxt;
    misv_word_t toff_r, toff_nxt;
    misv_word_t ton_r, ton_nxt;
    misv_word_t refrb_r, refrb_nxt;
    misv_word_t loop_r, loop_nxt;
    logic lmon_en_r, lmon_en_nxt;
    logic test_pend_nxt;
    logic fault_r, fault_nxt;
    logic wr_d_r, rd_d_r;
    logic act_r, act_nxt;
    misv_word_t rd_mux;
    misv_word_t drv_a_r, drv_b_r, drv_c_r;
    logic oe_a_r, oe_b_r, oe_c_r;
    logic drv_bad;
    logic cmd_wr;
    logic [15:0] closed_pt, fault_pt;

    // switch open sits above the on/off threshold
    assign closed_pt = ~smp_onoff_r;
    // above open threshold: wire open; below short threshold: wire short
    assign fault_pt = (smp_open_r | ~smp_short_r)
                      & {16{lmon_en_r & ~ac_s2_r}};
    assign cmd_wr = wr_v && !wr_d_r && (addr_v == `MISV_ADDR_CMD);
    // copies must agree; a lone driver slip is a module fault
    assign drv_bad = (oe_a_r || oe_b_r || oe_c_r) &&
                     ((drv_a_r != drv_b_r) || (drv_a_r != drv_c_r)
                      || (oe_a_r != oe_b_r) || (oe_a_r != oe_c_r));

    always_comb begin
        case (addr_v)
            `MISV_ADDR_INPUT: rd_mux = in_st_r;
            `MISV_ADDR_LINE: rd_mux = ln_st_r;
            `MISV_ADDR_TOFF: rd_mux = toff_r;
            `MISV_ADDR_TON: rd_mux = ton_r;
            `MISV_ADDR_REFRB: rd_mux = refrb_r;
            `MISV_ADDR_IDENT: rd_mux = `MISV_IDENT_CODE;
            `MISV_ADDR_LOOP: rd_mux = loop_r;
            default: rd_mux = {12'h000, lmon_en_r, 1'b0, fault_r, test_pend_r};
        endcase
    end

    always_comb begin
        in_st_nxt = in_st_r;
        ln_st_nxt = ln_st_r;
        toff_nxt = toff_r;
        ton_nxt = ton_r;
        refrb_nxt = refrb_r;
        loop_nxt = loop_r;
        lmon_en_nxt = lmon_en_r;
        test_pend_nxt = test_pend_r;
        fault_nxt = fault_r;
        act_nxt = act_r;
        if (xfer_r) begin
            in_st_nxt = closed_pt;
            ln_st_nxt = fault_pt;
            // test_run_r already names the scan now starting: request taken
            if (test_run_r) begin
                test_pend_nxt = 1'b0;
            end
            if (xfer_test_r) begin
                toff_nxt = smp_toff_r;
                ton_nxt = smp_ton_r;
                refrb_nxt = {1'b1, cmp_ok_r, 6'h00, rmon_r};
            end
        end
        if (wr_v && !wr_d_r && (addr_v == `MISV_ADDR_LOOP)) begin
            loop_nxt = wdata_v;
        end
        if (cmd_wr) begin
            lmon_en_nxt = wdata_v[`MISV_CMD_LMON];
            if (wdata_v[`MISV_CMD_TEST]) begin
                test_pend_nxt = 1'b1;
                refrb_nxt[`MISV_RB_DONE] = 1'b0;
            end
            if (wdata_v[`MISV_CMD_CLEAR]) begin
                fault_nxt = 1'b0;
            end
        end
        // set wins over a clear in the same cycle
        if ((cmd_wr && wdata_v[`MISV_CMD_FAULT]) || drv_bad) begin
            fault_nxt = 1'b1;
        end
        // green toggles once per controller input read
        if (rd_v && !rd_d_r && (addr_v == `MISV_ADDR_INPUT)) begin
            act_nxt = !act_r;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_st_r <= 16'h0000;
            ln_st_r <= 16'h0000;
            toff_r <= 16'h0000;
            ton_r <= 16'h0000;
            refrb_r <= 16'h0000;
            loop_r <= 16'h0000;
            lmon_en_r <= 1'b0;
            test_pend_r <= 1'b0;
            fault_r <= 1'b0;
            act_r <= 1'b0;
            wr_d_r <= 1'b0;
            rd_d_r <= 1'b0;
        end else begin
            in_st_r <= in_st_nxt;
            ln_st_r <= ln_st_nxt;
            toff_r <= toff_nxt;
            ton_r <= ton_nxt;
            refrb_r <= refrb_nxt;
            loop_r <= loop_nxt;
            lmon_en_r <= lmon_en_nxt;
            test_pend_r <= test_pend_nxt;
            fault_r <= fault_nxt;
            act_r <= act_nxt;
            wr_d_r <= wr_v;
            rd_d_r <= rd_v;
        end
    end

    // one register set per leg so a stuck driver stays on its own leg
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drv_a_r <= 16'h0000;
            drv_b_r <= 16'h0000;
            drv_c_r <= 16'h0000;
            oe_a_r <= 1'b0;
            oe_b_r <= 1'b0;
            oe_c_r <= 1'b0;
            dac_code_o <= 8'h00;
            led_active_o <= 1'b0;
            led_fault_o <= 1'b0;
            led_contact_o <= 16'h0000;
            led_line_o <= 16'h0000;
        end else begin
            drv_a_r <= rd_v ? rd_mux : 16'h0000;
            drv_b_r <= rd_v ? rd_mux : 16'h0000;
            drv_c_r <= rd_v ? rd_mux : 16'h0000;
            oe_a_r <= rd_v;
            oe_b_r <= rd_v;
            oe_c_r <= rd_v;
            dac_code_o <= dac_r;
            led_active_o <= act_r && !fault_r;
            led_fault_o <= fault_r;
            led_contact_o <= in_st_r | (ln_st_r & ~smp_short_r);
            led_line_o <= ln_st_r;
        end
    end

    assign bus_a_rdata_o = drv_a_r;
    assign bus_b_rdata_o = drv_b_r;
    assign bus_c_rdata_o = drv_c_r;
    assign bus_a_rdata_oe_o = oe_a_r;
    assign bus_b_rdata_oe_o = oe_b_r;
    assign bus_c_rdata_oe_o = oe_c_r;
endmodule

// ### sim/misv_proc_model.sv
`timescale 1ns/100ps
module misv_proc_model import misv_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [2:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [1:0] bad_leg_i,
    output logic [2:0][2:0] addr_o,
    output logic [2:0] rd_o,
    output logic [2:0] wr_o,
    output logic [2:0][15:0] wdata_o
);
    // each processor sends its own copy; one leg may carry inverted data
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_o <= '0;
            rd_o <= '0;
            wr_o <= '0;
            wdata_o <= '0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                addr_o[k] <= addr_i ^ {3{bad_leg_i == 2'(k + 1)}};
                rd_o[k] <= rd_i ^ (bad_leg_i == 2'(k + 1));
                wr_o[k] <= wr_i ^ (bad_leg_i == 2'(k + 1));
                wdata_o[k] <= wdata_i ^ {16{bad_leg_i == 2'(k + 1)}};
            end
        end
    end
endmodule

// ### sim/misv_top_monitor.sv
`timescale 1ns/100ps
`include "misv_defs.svh"
module misv_top_monitor import misv_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [2:0] bus_a_addr_i,
    input wire logic bus_a_rd_i,
    input wire logic bus_a_wr_i,
    input wire logic [2:0] bus_b_addr_i,
    input wire logic bus_b_rd_i,
    input wire logic bus_b_wr_i,
    input wire logic [2:0] bus_c_addr_i,
    input wire logic bus_c_rd_i,
    input wire logic bus_c_wr_i,
    input wire logic [15:0] bus_a_rdata_o,
    input wire logic bus_a_rdata_oe_o,
    input wire logic [15:0] bus_b_rdata_o,
    input wire logic bus_b_rdata_oe_o,
    input wire logic [15:0] bus_c_rdata_o,
    input wire logic bus_c_rdata_oe_o,
    input wire logic [7:0] dac_code_o,
    input wire logic led_active_o,
    input wire logic led_fault_o
);
    wire logic rd_v = (bus_a_rd_i & bus_b_rd_i) | (bus_b_rd_i & bus_c_rd_i)
        | (bus_a_rd_i & bus_c_rd_i);
    wire logic wr_v = (bus_a_wr_i & bus_b_wr_i) | (bus_b_wr_i & bus_c_wr_i)
        | (bus_a_wr_i & bus_c_wr_i);
    wire logic [2:0] addr_v = (bus_a_addr_i & bus_b_addr_i) | (bus_b_addr_i & bus_c_addr_i)
        | (bus_a_addr_i & bus_c_addr_i);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_oe_same;
        bus_a_rdata_oe_o == bus_b_rdata_oe_o && bus_b_rdata_oe_o == bus_c_rdata_oe_o;
    endproperty
    a_oe_same: assert property (p_oe_same) else $error("driver enables differ");
    property p_data_same;
        bus_a_rdata_oe_o |-> bus_a_rdata_o == bus_b_rdata_o && bus_b_rdata_o == bus_c_rdata_o;
    endproperty
    a_data_same: assert property (p_data_same) else $error("leg data differ");
    property p_idle_zero;
        !bus_a_rdata_oe_o |-> bus_a_rdata_o == 16'h0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("data while not driving");
    property p_ident;
        (rd_v && addr_v == `MISV_ADDR_IDENT)[*4]
            |-> bus_a_rdata_oe_o && bus_a_rdata_o == `MISV_IDENT_CODE;
    endproperty
    a_ident: assert property (p_ident) else $error("ident read wrong");
    property p_oe_cause;
        $rose(bus_a_rdata_oe_o) |-> $past(rd_v, 3);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("drive without voted read");
    property p_oe_drop;
        (!rd_v)[*4] |-> !bus_a_rdata_oe_o;
    endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("drive held after read");
    property p_dac_legal;
        dac_code_o inside {8'h00, 8'h0C, 8'h16, 8'h28, 8'h30, 8'h38, 8'h48, 8'h50, 8'h60, 8'h70, 8'hA0};
    endproperty
    a_dac_legal: assert property (p_dac_legal) else $error("bad reference code");
    property p_fault_dark;
        led_fault_o |-> !led_active_o;
    endproperty
    a_fault_dark: assert property (p_fault_dark) else $error("green lit on fault");
    property p_fault_sticky;
        (led_fault_o && !wr_v)[*4] |=> led_fault_o;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault lost");
endmodule
bind misv_top misv_top_monitor misv_top_monitor_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .bus_a_addr_i(bus_a_addr_i), .bus_a_rd_i(bus_a_rd_i), .bus_a_wr_i(bus_a_wr_i),
    .bus_b_addr_i(bus_b_addr_i), .bus_b_rd_i(bus_b_rd_i), .bus_b_wr_i(bus_b_wr_i),
    .bus_c_addr_i(bus_c_addr_i), .bus_c_rd_i(bus_c_rd_i), .bus_c_wr_i(bus_c_wr_i),
    .bus_a_rdata_o(bus_a_rdata_o), .bus_a_rdata_oe_o(bus_a_rdata_oe_o),
    .bus_b_rdata_o(bus_b_rdata_o), .bus_b_rdata_oe_o(bus_b_rdata_oe_o),
    .bus_c_rdata_o(bus_c_rdata_o), .bus_c_rdata_oe_o(bus_c_rdata_oe_o),
    .dac_code_o(dac_code_o), .led_active_o(led_active_o), .led_fault_o(led_fault_o));

// ### sim/misv_top_test.sv
`timescale 1ns/100ps
`include "misv_defs.svh"
module misv_top_test;
    import misv_pkg::*;
    logic sys_clk_i, reset_n_i, ac, q_rd, q_wr, la, lf;
    logic [15:0] cmp, q_wdata, ra, rb, rc, lcon, lln;
    logic [7:0] ref_mon, dac;
    logic [2:0] q_addr, l_rd, l_wr, oe;
    logic [1:0] q_bad;
    logic [2:0][2:0] l_addr;
    logic [2:0][15:0] l_wdata;
    int err_total, tests_run, st[16], stable, dmax;
    logic [31:0] seed;
    logic [15:0] d;
    // test spacing scaled from seconds to clock cycles
    localparam int io_unit_count = 1;
    localparam int program_scan_time = 1;
    localparam int test_interval_seconds = 172 * io_unit_count * program_scan_time + 2;
    misv_proc_model misv_proc_model_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .addr_i(q_addr), .rd_i(q_rd), .wr_i(q_wr), .wdata_i(q_wdata), .bad_leg_i(q_bad),
        .addr_o(l_addr), .rd_o(l_rd), .wr_o(l_wr), .wdata_o(l_wdata));
    misv_top misv_top_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cmp_i(cmp),
        .ref_mon_i(ref_mon), .ac_variant_i(ac),
        .bus_a_addr_i(l_addr[0]), .bus_a_rd_i(l_rd[0]), .bus_a_wr_i(l_wr[0]),
        .bus_a_wdata_i(l_wdata[0]),
        .bus_b_addr_i(l_addr[1]), .bus_b_rd_i(l_rd[1]), .bus_b_wr_i(l_wr[1]),
        .bus_b_wdata_i(l_wdata[1]),
        .bus_c_addr_i(l_addr[2]), .bus_c_rd_i(l_rd[2]), .bus_c_wr_i(l_wr[2]),
        .bus_c_wdata_i(l_wdata[2]),
        .bus_a_rdata_o(ra), .bus_a_rdata_oe_o(oe[0]), .bus_b_rdata_o(rb), .bus_b_rdata_oe_o(oe[1]),
        .bus_c_rdata_o(rc), .bus_c_rdata_oe_o(oe[2]), .dac_code_o(dac), .led_active_o(la),
        .led_fault_o(lf), .led_contact_o(lcon), .led_line_o(lln));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // field model: 0/8/16/24 V inputs, comparator slow to follow a new reference
    always @(posedge sys_clk_i) begin
        stable <= (dac != ref_mon) ? 0 : stable + 1;
        ref_mon <= dac;
        for (int i = 0; i < 16; i++)
            if (stable >= 100) cmp[i] <= (32 + 32 * st[i]) > int'(dac);
    end
    function automatic logic [15:0] exp_word(input int kind, input int code);
        logic [15:0] w;
        for (int i = 0; i < 16; i++)
            case (kind)
                0: w[i] = st[i] <= 1;
                1: w[i] = st[i] == 0 || st[i] == 3;
                default: w[i] = (32 + 32 * st[i]) > code;
            endcase
        return w;
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic read_word(input logic [2:0] a, input logic [1:0] bad, input logic [15:0] exp);
        q_addr <= a;
        q_rd <= 1'b1;
        q_bad <= bad;
        repeat (6) @(posedge sys_clk_i);
        #1;
        check("leg a data", exp, ra);
        check("leg b data", exp, rb);
        check("leg c data", exp, rc);
        check("enables", 16'h0007, {13'h0, oe});
        @(posedge sys_clk_i);
        q_rd <= 1'b0;
        q_bad <= 2'h0;
        repeat (6) @(posedge sys_clk_i);
    endtask
    task automatic write_word(input logic [2:0] a, input logic [1:0] bad, input logic [15:0] w);
        q_addr <= a;
        q_wdata <= w;
        q_wr <= 1'b1;
        q_bad <= bad;
        repeat (6) @(posedge sys_clk_i);
        q_wr <= 1'b0;
        q_bad <= 2'h0;
        repeat (6) @(posedge sys_clk_i);
    endtask
    task automatic wait_scan(input int n);
        dmax = 0;
        repeat (n) begin
            @(posedge sys_clk_i);
            if (int'(dac) > dmax) dmax = int'(dac);
        end
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        err_total++;
        report_and_stop();
    end
    initial begin
        {reset_n_i, ac, q_rd, q_wr, q_addr, q_wdata, q_bad, cmp, ref_mon} = '0;
        err_total = 0;
        tests_run = 0;
        stable = 0;
        seed = 32'h1311A5EC;
        for (int i = 0; i < 16; i++) st[i] = 0;
        repeat (10) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            read_word(`MISV_ADDR_IDENT, 2'(b), `MISV_IDENT_CODE);
            seed = xs(seed);
            write_word(`MISV_ADDR_LOOP, 2'(b), seed[15:0]);
            read_word(`MISV_ADDR_LOOP, 2'(3 - b), seed[15:0]);
        end
        write_word(`MISV_ADDR_IDENT, 2'h0, 16'h0000);
        read_word(`MISV_ADDR_IDENT, 2'h0, `MISV_IDENT_CODE);
        write_word(`MISV_ADDR_CMD, 2'h2, 16'h0008);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            st[i] = int'(seed[1:0]);
        end
        wait_scan(1600);
        check("max ref", 16'h0070, 16'(dmax));
        read_word(`MISV_ADDR_INPUT, 2'h1, exp_word(0, 0));
        read_word(`MISV_ADDR_LINE, 2'h3, exp_word(1, 0));
        d = {15'h0, la};
        read_word(`MISV_ADDR_INPUT, 2'h0, exp_word(0, 0));
        check("green toggles", {15'h0, ~d[0]}, {15'h0, la});
        check("contact leds", exp_word(0, 0), lcon);
        check("line leds", exp_word(1, 0), lln);
        read_word(`MISV_ADDR_CMD, 2'h0, 16'h0008);
        // done bit cleared by each request, so every pass proves a fresh test
        repeat (4) begin
            repeat (test_interval_seconds) @(posedge sys_clk_i);
            write_word(`MISV_ADDR_CMD, 2'h0, 16'h0009);
            wait_scan(2100);
            check("max test ref", 16'h00A0, 16'(dmax));
            read_word(`MISV_ADDR_TOFF, 2'h0, exp_word(2, 12));
            read_word(`MISV_ADDR_TON, 2'h0, exp_word(2, 160));
            read_word(`MISV_ADDR_REFRB, 2'h0, 16'hC0A0);
        end
        // fault set by a command write with leg a inverted, then cleared
        write_word(`MISV_ADDR_CMD, 2'h1, 16'h000A);
        check("fault led", 16'h0001, {15'h0, lf});
        check("green on fault", 16'h0000, {15'h0, la});
        write_word(`MISV_ADDR_CMD, 2'h0, 16'h000C);
        check("fault cleared", 16'h0000, {15'h0, lf});
        ac <= 1'b1;
        wait_scan(1600);
        wait_scan(900);
        check("max ac ref", 16'h0048, 16'(dmax));
        read_word(`MISV_ADDR_LINE, 2'h0, 16'h0000);
        report_and_stop();
    end
endmodule
